/* qmcd_defines.svh */
// Purpose: Constants for the host-side four-lane flash command controller
// Assumes: Included by the host and bench modules by bare name
// Notes:   Offsets are byte addresses on the AHB-Lite slave
`ifndef QMCD_DEFINES_SVH
`define QMCD_DEFINES_SVH
`define QMCD_OFF_CTRL     8'h00
`define QMCD_OFF_ADDR     8'h04
`define QMCD_OFF_WDATA    8'h08
`define QMCD_OFF_RDATA    8'h0c
`define QMCD_OFF_STATUS   8'h10
`define QMCD_OFF_PARAM    8'h14
`define QMCD_OP_WREN      8'h06
`define QMCD_OP_WRDI      8'h04
`define QMCD_OP_VSR_WREN  8'h50
`define QMCD_OP_SUSPEND   8'h75
`define QMCD_OP_RESUME    8'h7a
`define QMCD_OP_RELEASE   8'hab
`define QMCD_OP_PROG      8'h02
`define QMCD_OP_SEC_PROG  8'h42
`define QMCD_OP_SEC_ERASE 8'h44
`define QMCD_OP_WRAP_RD   8'h0c
`define QMCD_OP_FAST_RD   8'h0b
`define QMCD_OP_QIO_RD    8'heb
`define QMCD_OP_WORD_RD   8'he7
`define QMCD_OP_OCT_RD    8'he3
`define QMCD_OP_SET_WRAP  8'h77
`define QMCD_OP_SET_PARAM 8'hc0
`define QMCD_OP_RDSR1     8'h05
`define QMCD_OP_WRSR1     8'h01
`define QMCD_OP_ERASE4K   8'h20
`define QMCD_OP_CHIP_ER   8'hc7
`define QMCD_OP_CHIP_ER2  8'h60
`define QMCD_OP_BLK32     8'h52
`define QMCD_OP_BLK64     8'hd8
`define QMCD_PAGE_MAX     9'h100
`define QMCD_SEC_HI       8'h00
`define QMCD_SEC_R1       8'h10
`define QMCD_SEC_R2       8'h20
`define QMCD_SEC_R3       8'h30
`define QMCD_ID_DUMMY     4'h6
`define QMCD_QIO_DUMMY    4'h4
`define QMCD_WORD_DUMMY   4'h2
`define QMCD_DIV          4'h4
`define QMCD_CTRL_GO      0
`define QMCD_CTRL_MORE    1
`define QMCD_CTRL_END     2
`define QMCD_SER_WREN     3
`endif

/* qmcd_pkg.sv */
// Purpose: Types for the host-side four-lane flash command controller
// Assumes: qmcd_defines.svh present
// Notes:   Link pins carried as a packed struct, states as an enum
package qmcd_pkg;
  typedef struct packed {
    logic       sel_n;
    logic       sclk;
    logic [3:0] io_o;
    logic [3:0] io_oe;
  } qmcd_link_s;
  typedef enum logic [2:0] {
    QMCD_IDLE  = 3'b000,
    QMCD_OPC   = 3'b001,
    QMCD_ADR   = 3'b010,
    QMCD_DUMMY = 3'b011,
    QMCD_WDAT  = 3'b100,
    QMCD_RDAT  = 3'b101,
    QMCD_HOLD  = 3'b110,
    QMCD_DONE  = 3'b111
  } qmcd_state_e;
endpackage

/* qmcd_nib_shift.sv */
// Purpose: Byte to nibble serialiser and nibble to byte collector
// Assumes: Upper nibble first, lane 3 carries the nibble MSB
// Notes:   Advances on shift enable only
`timescale 1ns/1ps
module qmcd_nib_shift
  import qmcd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       load_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       shift_i,
  input  wire logic [3:0] nib_i,
  output logic      [3:0] nib_o,
  output logic      [7:0] byte_o
);
  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
  } qmcd_sh_s;
  qmcd_sh_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.tx = byte_i;
    end else if (shift_i) begin
      s_d.tx = {s_q.tx[3:0], 4'h0};
    end
    if (shift_i) begin
      s_d.rx = {s_q.rx[3:0], nib_i};
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign nib_o  = s_q.tx[7:4];
  assign byte_o = s_q.rx;
endmodule // qmcd_nib_shift

/* qmcd_host.sv */
// Purpose: Host controller driving a four-lane command mode serial flash
// Assumes: Flash already in four-lane command mode; AHB-Lite single word access
// Notes:   Software issues commands byte by byte through registers
`timescale 1ns/1ps
`include "qmcd_defines.svh"
module qmcd_host
  import qmcd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [3:0]  io_i,
  output logic             sel_n_o,
  output logic             sclk_o,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o
);
  typedef struct packed {
    qmcd_state_e st;
    logic        ap;
    logic        aw;
    logic [7:0]  aa;
    logic [7:0]  opc;
    logic [23:0] adr;
    logic [7:0]  mode;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    logic [7:0]  param;
    logic        write_enable_latch;
    logic        rvalid;
    logic        wfree;
    logic        go_more;
    logic        go_end;
    logic        refused;
    logic [8:0]  pcnt;
    logic [3:0]  div;
    logic        ph;
    logic        nib;
    logic [2:0]  bcnt;
    logic [4:0]  dcnt;
    logic        sclk;
    logic        sel_n;
    logic [3:0]  io_s1;
    logic [3:0]  io_s2;
    logic [7:0]  hold_b;
  } qmcd_st_s;
  qmcd_st_s   s_q, s_d;
  logic       tick;
  logic       ld;
  logic       sh;
  logic [7:0] ld_b;
  logic [3:0] nib;
  logic [7:0] rx_b;
  logic       needs_wel;
  logic       is_write;
  logic [4:0] dummies;

  qmcd_nib_shift u_sh (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (ld),
    .byte_i  (ld_b),
    .shift_i (sh),
    .nib_i   (s_q.io_s2),
    .nib_o   (nib),
    .byte_o  (rx_b)
  );

  assign tick = (s_q.div == `QMCD_DIV - 4'h1);
  always_comb begin
    unique case (s_q.opc)
      `QMCD_OP_PROG, `QMCD_OP_SEC_PROG, `QMCD_OP_SEC_ERASE, `QMCD_OP_WRSR1,
      `QMCD_OP_ERASE4K, `QMCD_OP_CHIP_ER, `QMCD_OP_CHIP_ER2,
      `QMCD_OP_BLK32, `QMCD_OP_BLK64: needs_wel = 1'b1;
      default: needs_wel = 1'b0;
    endcase
  end
  assign is_write = (s_q.opc == `QMCD_OP_PROG) || (s_q.opc == `QMCD_OP_SEC_PROG)
                 || (s_q.opc == `QMCD_OP_WRSR1) || (s_q.opc == `QMCD_OP_SET_PARAM);
  always_comb begin
    unique case (s_q.opc)
      `QMCD_OP_FAST_RD, `QMCD_OP_WRAP_RD: dummies = {1'b0, s_q.param[7:4]};
      `QMCD_OP_QIO_RD:  dummies = {1'b0, `QMCD_QIO_DUMMY};
      `QMCD_OP_WORD_RD: dummies = {1'b0, `QMCD_WORD_DUMMY};
      `QMCD_OP_OCT_RD:  dummies = 5'h0;
      `QMCD_OP_RELEASE: dummies = {1'b0, `QMCD_ID_DUMMY};
      default:          dummies = 5'h0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    ld = 1'b0;
    ld_b = s_q.opc;
    sh = 1'b0;
    s_d.io_s1 = io_i;
    s_d.io_s2 = s_q.io_s1;
    s_d.div = tick ? 4'h0 : s_q.div + 4'h1;
    // Bus address phase capture
    if (hsel_i && hready_i && htrans_i[1]) begin
      s_d.ap = 1'b1;
      s_d.aw = hwrite_i;
      s_d.aa = haddr_i[7:0];
    end else if (hready_i) begin
      s_d.ap = 1'b0;
    end
    if (s_q.ap && s_q.aw) begin
      unique case (s_q.aa)
        `QMCD_OFF_CTRL: begin
          s_d.opc     = hwdata_i[15:8];
          s_d.go_more = hwdata_i[`QMCD_CTRL_MORE];
          s_d.go_end  = hwdata_i[`QMCD_CTRL_END];
          if (hwdata_i[`QMCD_CTRL_GO] && s_q.st == QMCD_IDLE) begin
            s_d.st      = QMCD_OPC;
            s_d.refused = 1'b0;
            s_d.pcnt    = 9'h0;
          end
        end
        `QMCD_OFF_ADDR: begin
          s_d.adr  = hwdata_i[23:0];
          s_d.mode = hwdata_i[31:24];
        end
        `QMCD_OFF_WDATA: begin
          s_d.wdat  = hwdata_i[7:0];
          s_d.wfree = 1'b0;
        end
        `QMCD_OFF_PARAM: s_d.param = hwdata_i[7:0];
        default: ;
      endcase
    end
    if (s_q.ap && !s_q.aw && s_q.aa == `QMCD_OFF_RDATA) begin
      s_d.rvalid = 1'b0;
    end
    unique case (s_q.st)
      QMCD_IDLE: begin
        s_d.sel_n = 1'b1;
        s_d.sclk  = 1'b0;
      end
      QMCD_OPC: begin
        if (needs_wel && !s_q.write_enable_latch) begin
          s_d.refused = 1'b1;
          s_d.st      = QMCD_IDLE;
        end else if (tick) begin
          s_d.sel_n = 1'b0;
          ld        = 1'b1;
          ld_b      = s_q.opc;
          s_d.nib   = 1'b0;
          s_d.ph    = 1'b0;
          s_d.bcnt  = 3'h1;
          s_d.st    = QMCD_ADR;
          s_d.hold_b = s_q.opc;
        end
      end
      QMCD_ADR, QMCD_WDAT, QMCD_RDAT, QMCD_DUMMY: begin
        if (tick) begin
          s_d.sclk = ~s_q.ph;
          s_d.ph   = ~s_q.ph;
          if (s_q.ph) begin
            sh      = 1'b1;
            s_d.nib = ~s_q.nib;
            if (s_q.st == QMCD_DUMMY) begin
              s_d.dcnt = s_q.dcnt - 5'h1;
              if (s_q.dcnt == 5'h1) begin
                s_d.st = QMCD_RDAT;
              end
            end else if (s_q.nib) begin
              // Byte boundary
              if (s_q.st == QMCD_RDAT) begin
                s_d.rdat   = {rx_b[3:0], s_q.io_s2};
                s_d.rvalid = 1'b1;
                if (s_q.go_end) begin
                  s_d.st = QMCD_DONE;
                end
              end else if (s_q.bcnt <= 3'h3 && s_q.hold_b != `QMCD_OP_WREN &&
                           s_q.hold_b != `QMCD_OP_WRDI && s_q.hold_b != `QMCD_OP_VSR_WREN &&
                           s_q.hold_b != `QMCD_OP_SUSPEND && s_q.hold_b != `QMCD_OP_RESUME &&
                           !is_write && dummies == 5'h0 && s_q.hold_b != `QMCD_OP_SET_WRAP &&
                           s_q.hold_b != `QMCD_OP_RDSR1) begin
                ld     = 1'b1;
                ld_b   = s_q.adr[5'd23 - {s_q.bcnt - 3'h1, 3'h0} -: 8];
                s_d.bcnt = s_q.bcnt + 3'h1;
              end else if (s_q.bcnt <= 3'h3 && (is_write || dummies != 5'h0) &&
                           s_q.hold_b != `QMCD_OP_SET_PARAM && s_q.hold_b != `QMCD_OP_WRSR1 &&
                           s_q.hold_b != `QMCD_OP_RELEASE) begin
                ld     = 1'b1;
                ld_b   = s_q.adr[5'd23 - {s_q.bcnt - 3'h1, 3'h0} -: 8];
                s_d.bcnt = s_q.bcnt + 3'h1;
              end else if (s_q.bcnt == 3'h4 && s_q.hold_b == `QMCD_OP_QIO_RD) begin
                ld       = 1'b1;
                ld_b     = s_q.mode;
                s_d.bcnt = 3'h5;
              end else if (s_q.hold_b == `QMCD_OP_SET_WRAP && s_q.bcnt <= 3'h4) begin
                ld       = 1'b1;
                ld_b     = (s_q.bcnt == 3'h4) ? {1'b0, s_q.param[6:4], 4'h0} : 8'h0;
                s_d.bcnt = s_q.bcnt + 3'h1;
              end else if (is_write) begin
                if (s_q.pcnt != 9'h0 && (!s_q.go_more || s_q.pcnt == `QMCD_PAGE_MAX)) begin
                  s_d.st = QMCD_DONE;
                end else begin
                  ld       = 1'b1;
                  ld_b     = (s_q.hold_b == `QMCD_OP_SET_PARAM) ? s_q.param : s_q.wdat;
                  s_d.wfree = 1'b1;
                  s_d.pcnt = s_q.pcnt + 9'h1;
                  s_d.st   = QMCD_WDAT;
                end
              end else if (dummies != 5'h0) begin
                s_d.dcnt = dummies;
                s_d.st   = QMCD_DUMMY;
              end else if (s_q.hold_b == `QMCD_OP_RDSR1 || s_q.hold_b == `QMCD_OP_OCT_RD) begin
                s_d.st = QMCD_RDAT;
              end else begin
                s_d.st = QMCD_DONE;
              end
            end
          end
        end
      end
      QMCD_DONE: begin
        if (tick) begin
          s_d.sel_n = 1'b1;
          s_d.sclk  = 1'b0;
          s_d.st    = QMCD_HOLD;
          if (s_q.hold_b == `QMCD_OP_WREN) begin
            s_d.write_enable_latch = 1'b1;
          end else if (s_q.hold_b == `QMCD_OP_WRDI || needs_wel) begin
            s_d.write_enable_latch = 1'b0;
          end
        end
      end
      QMCD_HOLD: begin
        if (tick) begin
          s_d.st = QMCD_IDLE;
        end
      end
      default: s_d.st = QMCD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q        <= '0;
      s_q.st     <= QMCD_IDLE;
      s_q.sel_n  <= 1'b1;
      s_q.wfree  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    unique case (s_q.aa)
      `QMCD_OFF_RDATA:  hrdata_o = {24'h0, s_q.rdat};
      `QMCD_OFF_STATUS: hrdata_o = {27'h0, s_q.refused, s_q.wfree, s_q.rvalid, s_q.write_enable_latch,
                                    s_q.st != QMCD_IDLE};
      `QMCD_OFF_PARAM:  hrdata_o = {24'h0, s_q.param};
      default:          hrdata_o = 32'h0;
    endcase
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign sel_n_o     = s_q.sel_n;
  assign sclk_o      = s_q.sclk;
  assign io_o        = nib;
  assign io_oe_o     = (s_q.st == QMCD_ADR || s_q.st == QMCD_WDAT) ? 4'hf : 4'h0;
endmodule // qmcd_host

/* qmcd_flash_model.sv */
// Purpose: Behavioural four-lane flash device for the bench
// Assumes: Device already in four-lane command mode
// Notes:   Samples on rising sclk, drives on falling sclk
`timescale 1ns/1ps
module qmcd_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5a  // Arbitrary value
) (
  input  wire logic        sel_n_i,
  input  wire logic        sclk_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic             io_oe_o,
  output logic      [7:0]  op_o,
  output logic      [23:0] addr_o,
  output logic             wel_o,
  output int               frames_o
);
  int         n = 0;
  logic [7:0] rd;
  initial begin
    wel_o = 1'b0;
    frames_o = 0;
    io_oe_o = 1'b0;
    io_o = 4'h0;
  end
  always @(posedge sclk_i) begin
    if (!sel_n_i) begin
      if (n < 2) op_o <= {op_o[3:0], io_i};
      else if (n < 8) addr_o <= {addr_o[19:0], io_i};
      n <= n + 1;
    end
  end
  always @(negedge sclk_i) begin
    rd = (op_o == 8'hab) ? ID_CODE : {6'h0, wel_o, 1'b0};
    io_oe_o <= !sel_n_i && ((op_o == 8'h05 && n >= 2) || (op_o == 8'hab && n >= 8));
    io_o <= n[0] ? rd[3:0] : rd[7:4];
  end
  always @(posedge sel_n_i) begin
    frames_o <= frames_o + 1;
    n <= 0;
    io_oe_o <= 1'b0;
    if (n == 2 && op_o == 8'h06) wel_o <= 1'b1;
    if (n == 2 && op_o == 8'h04) wel_o <= 1'b0;
    if (n == 8 && (op_o == 8'h20 || op_o == 8'h44)) wel_o <= 1'b0;
  end
endmodule  // qmcd_flash_model

/* qmcd_host_asserts.sv */
// Purpose: Port checks for the host flash controller
// Assumes: Bound to qmcd_host
// Notes:   One clock domain
`timescale 1ns/1ps
module qmcd_host_asserts (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  input wire logic       sel_n_o,
  input wire logic       sclk_o,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_bus_okay: assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1) else $error("bus answer not okay");
  a_reset_idle: assert property ($rose(rst_n_i) |-> sel_n_o && !sclk_o && io_oe_o == 4'h0) else $error("not idle");
  a_desel_quiet: assert property (sel_n_o && $past(sel_n_o) |-> !sclk_o && io_oe_o == 4'h0) else $error("busy idle");
  a_lanes_whole: assert property (io_oe_o == 4'h0 || io_oe_o == 4'hf) else $error("partial lanes");
  a_clk_high: assert property ($rose(sclk_o) |=> sclk_o [*3] ##1 !sclk_o) else $error("high half wrong");
  a_clk_low: assert property ($fell(sclk_o) && !sel_n_o |=> !sclk_o [*3]) else $error("low half wrong");
  a_nibble_hold: assert property (sclk_o && $past(sclk_o) |-> $stable(io_o) && $stable(io_oe_o)) else $error("lane moved");
  a_sel_open: assert property ($fell(sel_n_o) |-> !sclk_o) else $error("select opened on high clock");
  a_frame_clk: assert property ($fell(sel_n_o) |-> ##[1:20] $rose(sclk_o)) else $error("no clock in frame");
  c_frame: cover property ($fell(sel_n_o));
  c_read: cover property (!sel_n_o && io_oe_o == 4'h0 && $rose(sclk_o));
  c_drive: cover property (io_oe_o == 4'hf && $rose(sclk_o));
endmodule  // qmcd_host_asserts

/* tb_top.sv */
// Purpose: Self-checking bench for the host flash controller
// Assumes: One AHB-Lite slave, flash model on the lanes
// Notes:   Random addresses and opcodes from a fixed seed
`timescale 1ns/1ps
`include "qmcd_defines.svh"
module tb_top;
  localparam logic [7:0] ID = 8'h5a;  // Arbitrary value
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hwrite_i = 1'b0;
  logic [1:0]  htrans_i = 2'b00;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, hr_q, r;
  logic        hreadyout_o, hresp_o, sel_n_o, sclk_o, m_oe, m_wel;
  logic [3:0]  io_o, io_oe_o, m_io, io_i, last = 4'h0;
  logic [7:0]  m_op, op;
  logic [23:0] m_addr, a;
  int          m_frames, f, errors = 0, comparisons = 0;
  qmcd_host u_qmcd_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .io_i(io_i), .sel_n_o(sel_n_o), .sclk_o(sclk_o), .io_o(io_o), .io_oe_o(io_oe_o));
  qmcd_flash_model #(.ID_CODE(ID)) u_qmcd_flash_model (.sel_n_i(sel_n_o), .sclk_i(sclk_o),
    .io_i(io_i), .io_o(m_io), .io_oe_o(m_oe), .op_o(m_op), .addr_o(m_addr), .wel_o(m_wel),
    .frames_o(m_frames));
  assign io_i = (io_oe_o == 4'hf) ? io_o : m_oe ? m_io : ~last;
  always @(posedge clk_i) last <= io_i;
  always @(posedge clk_i) hr_q <= hrdata_o;
  initial forever #5 clk_i = ~clk_i;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk_i);
    haddr_i <= {24'h0, ad};
    hwrite_i <= wr;
    htrans_i <= 2'b10;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    #1 r = hr_q;
  endtask
  task automatic cmd(input logic [7:0] code);
    int k;
    bus(1'b1, `QMCD_OFF_CTRL, {16'h0, code, 8'h05});
    repeat (8) @(posedge clk_i);
    k = 0;
    do begin
      bus(1'b0, `QMCD_OFF_STATUS, 32'h0);
      k++;
    end while (r[0] !== 1'b0 && k < 400);
    check("idle", {31'h0, r[0]}, 32'h0);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Longest plan is well under 30000 cycles
  initial begin
    #300000;
    errors++;
    results();
  end
  initial begin
    r = $urandom(32'hc06c);
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, `QMCD_OFF_STATUS, 32'h0);
    check("status reset", r & 32'h13, 32'h0);
    done("reset");
    f = m_frames;
    cmd(`QMCD_OP_PROG);
    check("refused", {31'h0, r[4]}, 32'h1);
    check("no frame", 32'(m_frames), 32'(f));
    done("gated");
    for (int i = 1; i <= 3; i++) begin
      a = {8'h00, i[3:0], 4'h0, 8'($urandom)};
      cmd(`QMCD_OP_WREN);
      check("wel host", {31'h0, r[1]}, 32'h1);
      check("wel dev", {31'h0, m_wel}, 32'h1);
      bus(1'b1, `QMCD_OFF_ADDR, {8'h0, a});
      cmd(`QMCD_OP_SEC_ERASE);
      check("sec addr", {8'h0, m_addr}, {8'h0, a});
      check("wel after", {31'h0, r[1]}, 32'h0);
    end
    done("security");
    cmd(`QMCD_OP_WREN);
    cmd(`QMCD_OP_WRDI);
    check("wel host", {31'h0, r[1]}, 32'h0);
    check("wel dev", {31'h0, m_wel}, 32'h0);
    done("disable");
    cmd(`QMCD_OP_WREN);
    for (int i = 0; i < 2; i++) begin
      cmd(i ? `QMCD_OP_RELEASE : `QMCD_OP_RDSR1);
      check("rvalid", {31'h0, r[2]}, 32'h1);
      bus(1'b0, `QMCD_OFF_RDATA, 32'h0);
      check("read byte", {24'h0, r[7:0]}, {24'h0, i ? ID : 8'h02});
      bus(1'b0, `QMCD_OFF_STATUS, 32'h0);
      check("rvalid clear", {31'h0, r[2]}, 32'h0);
    end
    done("reads");
    for (int i = 0; i < 8; i++) begin
      case (i % 4)
        0: op = `QMCD_OP_VSR_WREN;
        1: op = `QMCD_OP_SUSPEND;
        2: op = `QMCD_OP_RESUME;
        default: op = 8'h80 | 8'($urandom % 16);
      endcase
      f = m_frames;
      cmd(op);
      check("opcode", {24'h0, m_op}, {24'h0, op});
      check("frames", 32'(m_frames), 32'(f + 1));
      check("wel kept", {31'h0, m_wel}, 32'h1);
    end
    done("opcodes");
    op = 8'($urandom);
    bus(1'b1, `QMCD_OFF_PARAM, {24'h0, op});
    cmd(`QMCD_OP_SET_PARAM);
    check("param byte", {24'h0, m_addr[7:0]}, {24'h0, op});
    for (int i = 0; i < 2; i++) begin
      a = {8'($urandom), 8'($urandom), 8'($urandom)} & (i ? 24'hfffff0 : 24'hfffffe);
      bus(1'b1, `QMCD_OFF_ADDR, {8'h0, a});
      cmd(i ? `QMCD_OP_OCT_RD : `QMCD_OP_WORD_RD);
      check("aligned addr", {8'h0, m_addr}, {8'h0, a});
    end
    done("params");
    results();
  end
endmodule  // tb_top
bind qmcd_host qmcd_host_asserts u_qmcd_host_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sel_n_o(sel_n_o), .sclk_o(sclk_o),
  .io_o(io_o), .io_oe_o(io_oe_o));
